// ### design/jitter_atten_regs.svh
`ifndef JITTER_ATTEN_REGS_SVH
`define JITTER_ATTEN_REGS_SVH

// Register indices; byte address on the bus is four times the index
`define JA_IDX_RX_CTRL 8'h00
`define JA_IDX_TX_CTRL 8'h02
`define JA_IDX_RX_STAT 8'h20
`define JA_IDX_RX_IN_DIV 8'h21
`define JA_IDX_RX_OUT_DIV 8'h22
`define JA_IDX_RX_CFG 8'h23
`define JA_IDX_TX_STAT 8'h24
`define JA_IDX_TX_IN_DIV 8'h25
`define JA_IDX_TX_OUT_DIV 8'h26
`define JA_IDX_TX_CFG 8'h27

// Field positions
`define JA_STAT_UND 0
`define JA_STAT_OVR 1
`define JA_CFG_LIMIT 0
`define JA_CFG_OVR_EN 2
`define JA_CFG_UND_EN 3
`define JA_CFG_READ_POINTER_CENTRING 4
`define JA_CTRL_BYP 7

// Reset values
`define JA_DIV_RESET 8'h2f
`define JA_CFG_RESET 8'h00

// Timing and sizes
`define JA_MASTER_CLK_KHZ 49152
`define JA_NOM_DIV 5'd24
`define JA_FAST_DIV 5'd23
`define JA_SLOW_DIV 5'd25
`define JA_HALF_DIV 5'd12
`define JA_FIFO_DEPTH 6'd48
`define JA_FIFO_LAST 6'd47
`define JA_FIFO_MID 6'd24
`define JA_GUARD 6'd1
`define JA_PHASE_MAX 10'sd255

`endif

// ### design/jitter_atten_pkg.sv
package jitter_atten_pkg;

  // Rate decision of the digital PLL for the next smoothed clock period
  typedef enum logic [1:0] {
    SLEW_HOLD,
    SLEW_FAST,
    SLEW_SLOW
  } slew_t;

  typedef logic [7:0] reg_byte_t;

endpackage

// ### design/e1_jitter_attenuator.sv
// How it works
// - Smoothed clock comes from adaptively dividing the master clock by phase error
// - Reference clock is divided by input divider plus one before phase compare
// - Smoothed clock is divided by output divider plus one before phase compare
// - Loop averages the reference frequency; slow wander tracked, fast jitter smoothed
// - FIFO data is read out on the smoothed clock
// - The elastic FIFO holds 48 bits
// - Writing into a full FIFO sets the overflow flag, status bit 1
// - Reading an empty FIFO sets the underrun flag, status bit 0
// - Overflow and underrun raise the interrupt when their enable bits are set
// - Guard enable steers the clock rate to keep fill 1 UI from the ends
// - Centring control moves the read pointer to the FIFO middle
// - Bypass bit routes data and clock around the elastic FIFO
// - Separate receive and transmit attenuators, each with own registers and FIFO
// - Each framer's attenuators run independently of all others
// - Nominal smoothed clock is the master clock divided by 24
`timescale 1ns/1ps
`include "jitter_atten_regs.svh"

module e1_jitter_attenuator
  import jitter_atten_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] ref_clk_i,
  input wire logic [1:0] line_data_i,
  output logic [1:0] smooth_clk_o,
  output logic [1:0] smooth_data_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Shared decode helpers

  // Index of a per-path register: path 0 receive, path 1 transmit
  function automatic logic [7:0] path_idx(input logic path, input logic [7:0] rx_idx,
                                          input logic [7:0] tx_idx);
    path_idx = path ? tx_idx : rx_idx;
  endfunction

  // Circular pointer advance over the 48 cells
  function automatic logic [5:0] ptr_next(input logic [5:0] p);
    ptr_next = (p == `JA_FIFO_LAST) ? 6'h00 : p + 6'h01;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave front end
  //
  // Each register is one byte in the low lane of a 32-bit word.
  // A request is taken on the edge where cyc and stb are high and ack is low.
  // Ack follows one cycle later and lasts exactly one cycle.
  // A master that drops the request on the edge that samples ack is not served twice,
  // because ack_q masks the request in its own cycle; one that holds it longer is served again.
  // Writes with the low byte lane disabled are ignored on purpose.

  logic ack_q;
  logic [31:0] dat_q;
  logic irq_q;
  wire logic [7:0] bus_idx;
  wire logic bus_req;
  wire logic bus_wr;
  wire logic bus_rd;
  wire logic [7:0] path_rd [2];
  wire logic [1:0] path_irq;
  wire logic [7:0] rd_byte;

  // One access per request; ack drops in the cycle after it was given
  assign bus_idx = wb_adr_i[9:2];
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  assign bus_rd = bus_req & ~wb_we_i;
  assign rd_byte = path_rd[0] | path_rd[1];

  // Registered answer; unmapped indices read as zero and are still acked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
      irq_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
      dat_q <= bus_rd ? {24'h00_0000, rd_byte} : dat_q;
      irq_q <= |path_irq;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign irq_o = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Two independent attenuator paths
  //
  // Path 0 sits in the receive direction and path 1 in the transmit direction.
  // Nothing is shared between them except the bus decode and the interrupt OR.
  // Each path has:
  //   - a three-stage sampler on its reference clock and data pins
  //   - an input and an output divider feeding an up/down phase counter
  //   - a bang-bang rate choice that stretches or shortens one smoothed period
  //   - a 48-cell elastic store with circular write and read pointers
  //   - sticky overflow and underrun flags with per-flag enables
  // The smoothed clock is a level built from clk_i, not a real clock net.

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_path
      localparam logic PATH = (g == 1);

      logic [2:0] ref_s_q;
      logic [2:0] dat_s_q;
      logic ref_lvl_q;
      logic dat_lvl_q;
      logic [47:0] fifo_q;
      logic [5:0] wr_ptr_q;
      logic [5:0] rd_ptr_q;
      logic [5:0] fill_q;
      logic [4:0] div_cnt_q;
      logic [7:0] in_cnt_q;
      logic [7:0] out_cnt_q;
      logic signed [9:0] phase_q;
      logic [7:0] in_div_q;
      logic [7:0] out_div_q;
      logic [7:0] cfg_q;
      logic byp_q;
      logic [1:0] stat_q;
      logic clk_out_q;
      logic dat_out_q;
      slew_t slew;

      wire logic ref_lvl_d;
      wire logic dat_lvl_d;
      wire logic ref_rise;
      wire logic hit_ctrl;
      wire logic hit_stat;
      wire logic hit_in;
      wire logic hit_out;
      wire logic hit_cfg;
      wire logic read_pointer_centring_req;
      wire logic fifo_full;
      wire logic fifo_empty;
      wire logic wr_try;
      wire logic rd_try;
      wire logic do_wr;
      wire logic do_rd;
      wire logic [4:0] period;
      wire logic sm_tick;
      wire logic [4:0] div_cnt_d;
      wire logic in_pulse;
      wire logic out_pulse;
      wire logic signed [9:0] phase_sum;
      wire logic [1:0] stat_set;
      wire logic [1:0] stat_clr;
      wire logic [5:0] mid_ptr;

      // Three-stage pin sampling; a level counts once stages two and three agree
      // Stage one may go metastable, so only stage two reads it.
      // A pin pulse shorter than two clocks may be lost entirely.
      // The reference edge and the data level share the same delay,
      // so the bit written is the one that stood at the reference rise.
      assign ref_lvl_d = (ref_s_q[1] == ref_s_q[2]) ? ref_s_q[2] : ref_lvl_q;
      assign dat_lvl_d = (dat_s_q[1] == dat_s_q[2]) ? dat_s_q[2] : dat_lvl_q;
      assign ref_rise = ref_lvl_d & ~ref_lvl_q;

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ref_s_q <= 3'h0;
          dat_s_q <= 3'h0;
          ref_lvl_q <= 1'b0;
          dat_lvl_q <= 1'b0;
        end else begin
          ref_s_q <= {ref_s_q[1:0], ref_clk_i[g]};
          dat_s_q <= {dat_s_q[1:0], line_data_i[g]};
          ref_lvl_q <= ref_lvl_d;
          dat_lvl_q <= dat_lvl_d;
        end
      end

      // Register decode for this path
      assign hit_ctrl = bus_idx == path_idx(PATH, `JA_IDX_RX_CTRL, `JA_IDX_TX_CTRL);
      assign hit_stat = bus_idx == path_idx(PATH, `JA_IDX_RX_STAT, `JA_IDX_TX_STAT);
      assign hit_in = bus_idx == path_idx(PATH, `JA_IDX_RX_IN_DIV, `JA_IDX_TX_IN_DIV);
      assign hit_out = bus_idx == path_idx(PATH, `JA_IDX_RX_OUT_DIV, `JA_IDX_TX_OUT_DIV);
      assign hit_cfg = bus_idx == path_idx(PATH, `JA_IDX_RX_CFG, `JA_IDX_TX_CFG);
      assign read_pointer_centring_req = bus_wr & hit_cfg & wb_dat_i[`JA_CFG_READ_POINTER_CENTRING];

      // Software settings; the transmit bypass is left to software in clock master mode
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          in_div_q <= `JA_DIV_RESET;
          out_div_q <= `JA_DIV_RESET;
          cfg_q <= `JA_CFG_RESET;
          byp_q <= 1'b0;
        end else begin
          if (bus_wr && hit_in) begin
            in_div_q <= wb_dat_i[7:0];
          end
          if (bus_wr && hit_out) begin
            out_div_q <= wb_dat_i[7:0];
          end
          if (bus_wr && hit_cfg) begin
            cfg_q <= wb_dat_i[7:0];
          end
          if (bus_wr && hit_ctrl) begin
            byp_q <= wb_dat_i[`JA_CTRL_BYP];
          end
        end
      end

      // Read view; other bits of the control register read as zero
      assign path_rd[g] = ({8{hit_ctrl}} & {byp_q, 7'h00})
                        | ({8{hit_stat}} & {6'h00, stat_q})
                        | ({8{hit_in}} & in_div_q)
                        | ({8{hit_out}} & out_div_q)
                        | ({8{hit_cfg}} & cfg_q);

      // Phase discriminator inputs: both clocks divided before comparison
      // A positive count means the reference side is ahead of the smoothed side.
      // Larger dividers make each count step rarer, so the loop reacts more slowly
      // and attenuates lower jitter frequencies.
      // Changing a divider mid-run may leave a counter above its new limit;
      // it then wraps at 255 once, a one-time phase step the loop absorbs.
      assign in_pulse = ref_rise & (in_cnt_q == in_div_q);
      assign out_pulse = sm_tick & (out_cnt_q == out_div_q);
      assign phase_sum = phase_q + (in_pulse ? 10'sd1 : 10'sd0)
                       - (out_pulse ? 10'sd1 : 10'sd0);

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          in_cnt_q <= 8'h00;
          out_cnt_q <= 8'h00;
          phase_q <= 10'sd0;
        end else begin
          if (ref_rise) begin
            in_cnt_q <= in_pulse ? 8'h00 : in_cnt_q + 8'h01;
          end
          if (sm_tick) begin
            out_cnt_q <= out_pulse ? 8'h00 : out_cnt_q + 8'h01;
          end
          // Saturate so a long outage cannot wrap the error sign
          if (phase_sum > `JA_PHASE_MAX) begin
            phase_q <= `JA_PHASE_MAX;
          end else if (phase_sum < -`JA_PHASE_MAX) begin
            phase_q <= -`JA_PHASE_MAX;
          end else begin
            phase_q <= phase_sum;
          end
        end
      end

      // Rate choice: guard band overrides the phase error near full or empty
      // Without the guard the loop follows phase only and may run the store dry
      // or into overflow under large input jitter.
      // With it, attenuation is traded for fewer lost bits; a reference outside the 23 to 25 count period range still overflows or runs dry.
      // Holding rate at zero error avoids hunting between fast and slow.
      always_comb begin
        if (cfg_q[`JA_CFG_LIMIT] && fill_q <= `JA_GUARD) begin
          slew = SLEW_SLOW;
        end else if (cfg_q[`JA_CFG_LIMIT] && fill_q >= `JA_FIFO_DEPTH - `JA_GUARD) begin
          slew = SLEW_FAST;
        end else if (phase_q > 10'sd0) begin
          slew = SLEW_FAST;
        end else if (phase_q < 10'sd0) begin
          slew = SLEW_SLOW;
        end else begin
          slew = SLEW_HOLD;
        end
      end

      // One master-clock cycle stolen or added per period; small steps keep jitter low
      assign period = (slew == SLEW_FAST) ? `JA_FAST_DIV
                    : (slew == SLEW_SLOW) ? `JA_SLOW_DIV : `JA_NOM_DIV;
      assign sm_tick = div_cnt_q == period - 5'd1;
      assign div_cnt_d = sm_tick ? 5'd0 : div_cnt_q + 5'd1;

      // Elastic store status
      // Fill counts stored bits; full at 48 and empty at 0.
      // Write and read in one cycle leave the fill unchanged.
      // Bypass stops both pointers so the store keeps its old contents,
      // which reappear if bypass is later cleared without recentring.
      // Centring takes the write pointer as reference and puts the read
      // pointer half the store behind it.
      assign fifo_full = fill_q == `JA_FIFO_DEPTH;
      assign fifo_empty = fill_q == 6'd0;
      assign wr_try = ref_rise & ~byp_q;
      assign rd_try = sm_tick & ~byp_q;
      assign do_wr = wr_try & ~fifo_full;
      assign do_rd = rd_try & ~fifo_empty;
      assign mid_ptr = (wr_ptr_q >= `JA_FIFO_MID) ? wr_ptr_q - `JA_FIFO_MID
                                                  : wr_ptr_q + `JA_FIFO_MID;

      // Pointers and fill; a write into a full store is dropped
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          wr_ptr_q <= 6'h00;
          rd_ptr_q <= 6'h00;
          fill_q <= 6'h00;
          div_cnt_q <= 5'd0;
        end else begin
          div_cnt_q <= div_cnt_d;
          wr_ptr_q <= do_wr ? ptr_next(wr_ptr_q) : wr_ptr_q;
          if (read_pointer_centring_req) begin
            rd_ptr_q <= mid_ptr;
            fill_q <= `JA_FIFO_MID;
          end else begin
            rd_ptr_q <= do_rd ? ptr_next(rd_ptr_q) : rd_ptr_q;
            fill_q <= fill_q + {5'h00, do_wr} - {5'h00, do_rd};
          end
        end
      end

      // Storage cells, written on the reference side only
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          fifo_q <= 48'h0000_0000_0000;
        end else if (do_wr) begin
          fifo_q[wr_ptr_q] <= dat_lvl_d;
        end
      end

      // Output clock and data; underrun repeats the last bit
      // In bypass the pins pass through the sampler, so output edges lag the pins
      // by four clocks and keep the input jitter untouched.
      // High phase is the first 12 counts, so a stretched period lengthens low.
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          clk_out_q <= 1'b0;
          dat_out_q <= 1'b0;
        end else if (byp_q) begin
          clk_out_q <= ref_lvl_d;
          dat_out_q <= dat_lvl_d;
        end else begin
          clk_out_q <= div_cnt_d < `JA_HALF_DIV;
          dat_out_q <= do_rd ? fifo_q[rd_ptr_q] : dat_out_q;
        end
      end

      assign smooth_clk_o[g] = clk_out_q;
      assign smooth_data_o[g] = dat_out_q;

      // Sticky flags cleared by a status read; a new event wins over the clear
      assign stat_set[`JA_STAT_OVR] = wr_try & fifo_full;
      assign stat_set[`JA_STAT_UND] = rd_try & fifo_empty;
      assign stat_clr = {2{bus_rd & hit_stat}};

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          stat_q <= 2'h0;
        end else begin
          stat_q <= (stat_q & ~stat_clr) | stat_set;
        end
      end

      // Enables in the config register act as the interrupt mask
      assign path_irq[g] = (stat_q[`JA_STAT_OVR] & cfg_q[`JA_CFG_OVR_EN])
                         | (stat_q[`JA_STAT_UND] & cfg_q[`JA_CFG_UND_EN]);
    end
  endgenerate

endmodule // e1_jitter_attenuator

// ### sim/jitter_atten_properties.sv
`timescale 1ns/1ps
////////////////////////////////////////
module jitter_atten_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic [1:0] smooth_clk_o,
  input wire logic [1:0] smooth_data_o,
  input wire logic irq_o
);
  // Single domain; reset quiets every check
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Bus answer timing
  property p_ack_answer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
  property p_dat_upper; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
  // Receive path is never bypassed by the bench, so its clock stays divided
  property p_rx_period; $rose(smooth_clk_o[0]) |-> ##[23:25] $rose(smooth_clk_o[0]); endproperty
  property p_rx_high; $rose(smooth_clk_o[0]) |-> smooth_clk_o[0][*8]; endproperty
  // Mid low phase is far from the read, so data must hold there
  property p_rx_hold; $fell(smooth_clk_o[0]) |=> $stable(smooth_data_o[0])[*8]; endproperty
  // Flags only clear through a bus access
  property p_irq_fall; $fell(irq_o) |-> $past(wb_ack_o); endproperty

  a_ack_answer: assert property (p_ack_answer) else $error("bus request not answered");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_dat_upper: assert property (p_dat_upper) else $error("read data upper bits set");
  a_rx_period: assert property (p_rx_period) else $error("smoothed period off");
  a_rx_high: assert property (p_rx_high) else $error("smoothed high phase short");
  a_rx_hold: assert property (p_rx_hold) else $error("data moved mid period");
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped by itself");

  c_irq_rise: cover property ($rose(irq_o));
  c_ack_irq: cover property (wb_ack_o && irq_o);
  c_tx_short: cover property ($rose(smooth_clk_o[1]) ##6 $rose(smooth_clk_o[1]));
endmodule // jitter_atten_properties

bind e1_jitter_attenuator jitter_atten_properties u_props (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .wb_dat_o, .smooth_clk_o, .smooth_data_o, .irq_o);

// ### sim/line_source.sv
`timescale 1ns/1ps
////////////////////////////////////////
module line_source (
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic [4:0] half_i,
  output logic ref_o,
  output logic data_o
);
  logic [4:0] cnt_q = 5'd0;
  logic [2:0] seq_q = 3'd0;
  logic ref_q = 1'b0;
  logic data_q = 1'b0;

  assign ref_o = ref_q;
  assign data_o = data_q;

  // Data moves on the reference fall so it is steady at the rise
  always @(posedge clk_i) begin
    if (!en_i) begin
      cnt_q <= 5'd0;
      ref_q <= 1'b0;
      data_q <= ~data_q; // Released line toggles, never a stale level
    end else if (cnt_q + 5'd1 >= half_i) begin
      cnt_q <= 5'd0;
      ref_q <= ~ref_q;
      if (ref_q) begin
        seq_q <= seq_q + 3'd1;
        data_q <= seq_q[0] ^ seq_q[2];
      end
    end else begin
      cnt_q <= cnt_q + 5'd1;
    end
  end
endmodule // line_source

// ### sim/tb_top.sv
`timescale 1ns/1ps
////////////////////////////////////////
module tb_top;
  typedef struct packed {
    logic [7:0] idx;
    logic w;
    logic [7:0] d;
    logic [7:0] e;
  } row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h1;
  logic [31:0] dat = 32'h0, rdat;
  logic [1:0] ref_clk, line, sclk, sdata;
  logic [1:0] en = 2'b00;
  logic [4:0] half0 = 5'd12, half1 = 5'd12;
  logic [5:0] hc, hd;
  logic [7:0] r;
  int mismatches = 0, total_checks = 0;
  // Reset values first, then write and read back
  row_t rows [17] = '{'{8'h21,1'b0,8'h00,8'h2f}, '{8'h22,1'b0,8'h00,8'h2f},
    '{8'h25,1'b0,8'h00,8'h2f}, '{8'h26,1'b0,8'h00,8'h2f}, '{8'h23,1'b0,8'h00,8'h00},
    '{8'h27,1'b0,8'h00,8'h00}, '{8'h00,1'b0,8'h00,8'h00}, '{8'h02,1'b0,8'h00,8'h00},
    '{8'h21,1'b1,8'ha5,8'h00}, '{8'h21,1'b0,8'h00,8'ha5}, '{8'h26,1'b1,8'h3c,8'h00},
    '{8'h26,1'b0,8'h00,8'h3c}, '{8'h22,1'b0,8'h00,8'h2f}, '{8'h3f,1'b1,8'hff,8'h00},
    '{8'h3f,1'b0,8'h00,8'h00}, '{8'h02,1'b1,8'hff,8'h00}, '{8'h02,1'b0,8'h00,8'h80}};

  always #50 clk_i = ~clk_i;
  // Pin history for the bypass compare
  always @(posedge clk_i) begin
    hc <= {hc[4:0], ref_clk[1]};
    hd <= {hd[4:0], line[1]};
  end

  e1_jitter_attenuator u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .ref_clk_i(ref_clk), .line_data_i(line), .smooth_clk_o(sclk),
    .smooth_data_o(sdata), .irq_o(irq));
  line_source u_rx_src (.clk_i(clk_i), .en_i(en[0]), .half_i(half0), .ref_o(ref_clk[0]),
    .data_o(line[0]));
  line_source u_tx_src (.clk_i(clk_i), .en_i(en[1]), .half_i(half1), .ref_o(ref_clk[1]),
    .data_o(line[1]));

  ////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic cycle held until ack; no fixed latency assumed
  task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wait_irq;
    for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge clk_i);
    check({7'h0, irq}, 8'h01);
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog, far beyond the expected few thousand cycles
  initial begin
    #(100 * 20000);
    mismatches++;
    end_of_test;
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    en <= 2'b11;
    @(posedge clk_i);
    foreach (rows[i]) begin
      bus(rows[i].idx, rows[i].w, rows[i].d);
      if (!rows[i].w) check(r, rows[i].e);
    end
    // Transmit path now bypassed, as clock master setups need
    half1 <= 5'd3;
    repeat (80) begin
      @(posedge clk_i);
      #1;
      if ((hc[5:2] === 4'hf || hc[5:2] === 4'h0) && (hd[5:2] === 4'hf || hd[5:2] === 4'h0))
        check({6'h0, sclk[1], sdata[1]}, {6'h0, hc[2], hd[2]});
    end
    // Receive reference far faster than the read side drains the buffer
    half0 <= 5'd2;
    bus(8'h23, 1'b1, 8'h04);
    wait_irq;
    en[0] <= 1'b0;
    repeat (8) @(posedge clk_i);
    bus(8'h20, 1'b0, 8'h00);
    check(r & 8'h02, 8'h02);
    bus(8'h20, 1'b0, 8'h00);
    check(r & 8'h02, 8'h00);
    repeat (3) @(posedge clk_i);
    check({7'h0, irq}, 8'h00);
    // Reference stopped: buffer drains and runs dry, with only the underrun interrupt enabled
    bus(8'h23, 1'b1, 8'h08);
    wait_irq;
    bus(8'h20, 1'b0, 8'h00);
    check(r & 8'h01, 8'h01);
    // Recentre the dry store: half full again, so no underrun for a while
    bus(8'h23, 1'b1, 8'h10);
    bus(8'h20, 1'b0, 8'h00);
    repeat (200) @(posedge clk_i);
    bus(8'h20, 1'b0, 8'h00);
    check(r & 8'h01, 8'h00);
    bus(8'h23, 1'b1, 8'h00);
    repeat (3) @(posedge clk_i);
    check({7'h0, irq}, 8'h00);
    // Reset in mid-run
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    check({3'h0, sclk, sdata, irq}, 8'h00);
    @(posedge clk_i);
    rst_i <= 1'b0;
    bus(8'h21, 1'b0, 8'h00);
    check(r, 8'h2f);
    bus(8'h02, 1'b0, 8'h00);
    check(r, 8'h00);
    end_of_test;
  end
endmodule // tb_top
